//--- cie_pkg.sv
// Shared constants, types and decode helpers for the core execute slice
package cie_pkg;
  // Instruction cycle length in clocks
  localparam int unsigned PHASES = 4;

  // Register byte offsets on the bus
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_ACC = 8'h04;
  localparam logic [7:0] OFS_BANK = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0c;
  localparam logic [7:0] OFS_PTR0 = 8'h10;
  localparam logic [7:0] OFS_PTR1 = 8'h14;
  localparam logic [7:0] OFS_PTR2 = 8'h18;
  localparam logic [7:0] OFS_STATE = 8'h1c;

  // Control bits
  localparam int unsigned CTRL_EXT = 0;
  localparam int unsigned CTRL_RUN = 1;
  localparam logic [1:0] CTRL_RST = 2'h0;

  // Status bits
  localparam int unsigned ST_C = 0;
  localparam int unsigned ST_DC = 1;
  localparam int unsigned ST_Z = 2;
  localparam int unsigned ST_OV = 3;
  localparam int unsigned ST_N = 4;
  localparam logic [4:0] STATUS_RST = 5'h00;
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [3:0] BANK_RST = 4'h0;
  localparam logic [11:0] PTR_RST = 12'h000;

  // Instruction fields
  localparam int unsigned BIT_DIR = 9;
  localparam int unsigned BIT_ACC = 8;
  localparam logic [1:0] PTR_NONE = 2'h3;

  // Addressing
  localparam logic [7:0] INDEXED_MAX = 8'h5f;
  localparam logic [7:0] ACCESS_SPLIT = 8'h60;
  localparam logic [3:0] ACCESS_LOW = 4'h0;
  localparam logic [3:0] ACCESS_HIGH = 4'hf;
  localparam logic [11:0] ACC_LOC_DEF = 12'hfe8;

  // Opcodes
  localparam logic [7:0] OP_OR_LIT = 8'h09;
  localparam logic [7:0] OP_BANK = 8'h01;
  localparam logic [5:0] OP_OR_REG = 6'h04;
  localparam logic [5:0] OP_MOVE = 6'h14;
  localparam logic [5:0] OP_INC_SZ = 6'h0f;
  localparam logic [5:0] OP_INC_SNZ = 6'h12;
  localparam logic [9:0] OP_LDPTR = 10'h3b8;
  localparam logic [3:0] OP_MFF = 4'hc;
  localparam logic [6:0] OP_TWO_A = 7'h77;
  localparam logic [6:0] OP_TWO_B = 7'h76;

  typedef enum logic [3:0] {
    ST_EXEC = 4'b0001,
    ST_WORD2 = 4'b0010,
    ST_SKIP = 4'b0100,
    ST_SKIP2 = 4'b1000
  } cie_state_t;

  typedef struct packed {
    logic re;
    logic [11:0] addr;
  } cie_dm_rd_t;

  typedef struct packed {
    logic we;
    logic [11:0] addr;
    logic [7:0] data;
  } cie_dm_wr_t;

  // True for opcodes that occupy two program words
  function automatic logic is_two_word(input logic [15:0] w);
    return (w[15:12] == OP_MFF) || (w[15:9] == OP_TWO_A) || (w[15:9] == OP_TWO_B);
  endfunction : is_two_word
endpackage : cie_pkg

//--- cie_phase.sv
// Four-phase sequencer of the instruction cycle
`timescale 1ns/1ps
module cie_phase (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic run,
  output logic [3:0] q
);
  logic [3:0] q_r, q_nxt;

  // Rotate one-hot phase only while running; a halt freezes mid-cycle
  always_comb begin
    q_nxt = q_r;
    if (run) begin
      q_nxt = {q_r[2:0], q_r[3]};
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q_r <= 4'h1;
    end else begin
      q_r <= q_nxt;
    end
  end

  // Gated so that a halted core sees no phase at all
  assign q = q_r & {4{run}};
endmodule : cie_phase

//--- cie_core.sv
// Decode and execute slice: or, move, increment-skip, pointer, bank and file moves
`timescale 1ns/1ps
// Notes on behaviour
// - Or-literal ORs accumulator with low instruction byte into accumulator.
// - Or-register ORs accumulator with memory byte, result to chosen destination.
// - Direction bit 0 writes accumulator, 1 writes back the register.
// - Access bit 0 uses access bank, 1 takes upper bits from bank selector.
// - Access bit 0 with extended set: offsets up to 95 are pointer-indexed.
// - The 8-bit register field reaches all of the current 256-byte bank.
// - Register move copies the byte to accumulator or back to itself.
// - Register move decodes as 010100, direction, access, 8-bit address.
// - Both ORs and the move set only negative and zero flags.
// - Pointer load writes high part in cycle one, low byte in cycle two.
// - File-to-file move carries full 12-bit source and destination.
// - File-to-file move accepts the accumulator as source or destination.
// - File-to-file reads source in cycle one, writes destination in cycle two.
// - Bank load puts its literal into the bank selector in one cycle.
// - Upper four bits of the bank selector always read zero.
module cie_core #(
  parameter logic [11:0] ACC_LOC = cie_pkg::ACC_LOC_DEF
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic [15:0] instr_word,
  output logic instr_take,
  output cie_pkg::cie_dm_rd_t dm_rd,
  input wire logic [7:0] dm_rdata,
  output cie_pkg::cie_dm_wr_t dm_wr
);
  logic [3:0] q;
  cie_pkg::cie_state_t st_r, st_nxt;
  logic [15:0] ir_r, ir_nxt;
  logic [7:0] opnd_r, opnd_nxt, res_r, res_nxt, acc_r, acc_nxt;
  logic [3:0] bank_r, bank_nxt;
  logic [4:0] stat_r, stat_nxt;
  logic [1:0] ctrl_r, ctrl_nxt, pidx_r, pidx_nxt;
  logic pmff_r, pmff_nxt;
  logic [11:0] ptr_r [3];
  logic [11:0] ptr_nxt [3];
  cie_pkg::cie_dm_rd_t rd_r, rd_nxt;
  cie_pkg::cie_dm_wr_t wr_r, wr_nxt;
  logic bw_r, bw_nxt;
  logic [7:0] ba_r, ba_nxt;
  logic [31:0] hrdata_r, hrdata_nxt;
  logic [15:0] w;
  logic exec, word2, d_or_lit, d_bank, d_or_reg, d_move, d_inc_z, d_inc_nz;
  logic d_byte, d_ldptr, d_mff, bus_ph, skip_hit;

  cie_phase u_phase (
    .hclk(hclk),
    .hresetn(hresetn),
    .run(ctrl_r[cie_pkg::CTRL_RUN]),
    .q(q)
  );

  // Operand address of a byte-oriented instruction
  function automatic logic [11:0] eff_addr(input logic [7:0] f, input logic a,
                                           input logic ext, input logic [3:0] bk,
                                           input logic [11:0] p2);
    logic [11:0] r;
    r = 12'h000;
    if (a) begin
      r = {bk, f};
    end else if (ext && f <= cie_pkg::INDEXED_MAX) begin
      r = p2 + {4'h0, f};
    end else if (f < cie_pkg::ACCESS_SPLIT) begin
      r = {cie_pkg::ACCESS_LOW, f};
    end else begin
      r = {cie_pkg::ACCESS_HIGH, f};
    end
    return r;
  endfunction : eff_addr

  // Decode the word being taken in decode phase, else the held one
  assign w = q[0] ? instr_word : ir_r;
  assign exec = st_r == cie_pkg::ST_EXEC;
  assign word2 = st_r == cie_pkg::ST_WORD2;
  assign d_or_lit = w[15:8] == cie_pkg::OP_OR_LIT;
  assign d_bank = w[15:8] == cie_pkg::OP_BANK;
  assign d_or_reg = w[15:10] == cie_pkg::OP_OR_REG;
  assign d_move = w[15:10] == cie_pkg::OP_MOVE;
  assign d_inc_z = w[15:10] == cie_pkg::OP_INC_SZ;
  assign d_inc_nz = w[15:10] == cie_pkg::OP_INC_SNZ;
  assign d_byte = d_or_reg | d_move | d_inc_z | d_inc_nz;
  assign d_ldptr = w[15:6] == cie_pkg::OP_LDPTR;
  assign d_mff = w[15:12] == cie_pkg::OP_MFF;
  assign skip_hit = (d_inc_z && res_r == 8'h00) || (d_inc_nz && res_r != 8'h00);

  // Core next state: software writes first, then the running instruction
  always_comb begin
    st_nxt = st_r;
    ir_nxt = ir_r;
    opnd_nxt = opnd_r;
    res_nxt = res_r;
    acc_nxt = acc_r;
    bank_nxt = bank_r;
    stat_nxt = stat_r;
    ctrl_nxt = ctrl_r;
    pidx_nxt = pidx_r;
    pmff_nxt = pmff_r;
    ptr_nxt = ptr_r;
    rd_nxt = rd_r;
    wr_nxt = wr_r;
    if (bw_r) begin
      case (ba_r)
        cie_pkg::OFS_CTRL: ctrl_nxt = hwdata[1:0];
        cie_pkg::OFS_ACC: acc_nxt = hwdata[7:0];
        cie_pkg::OFS_BANK: bank_nxt = hwdata[3:0];
        cie_pkg::OFS_STATUS: stat_nxt = hwdata[4:0];
        default: ;
      endcase
    end
    // Decode phase: latch the word and launch the operand read
    if (q[0]) begin
      ir_nxt = instr_word;
      rd_nxt.re = 1'b0;
      if (exec && d_byte) begin
        rd_nxt.re = 1'b1;
        rd_nxt.addr = eff_addr(w[7:0], w[cie_pkg::BIT_ACC], ctrl_r[cie_pkg::CTRL_EXT],
                               bank_r, ptr_r[2]);
      end else if (exec && d_mff) begin
        rd_nxt.re = w[11:0] != ACC_LOC;
        rd_nxt.addr = w[11:0];
      end
    end
    // Read phase: a second word never reads
    if (q[1]) begin
      if (rd_r.re) begin
        opnd_nxt = dm_rdata;
      end else if (exec && d_mff) begin
        opnd_nxt = acc_r;
      end
      rd_nxt.re = 1'b0;
    end
    // Process phase: form the result and queue the memory write
    if (q[2]) begin
      if (d_or_lit) begin
        res_nxt = acc_r | w[7:0];
      end else if (d_or_reg) begin
        res_nxt = acc_r | opnd_r;
      end else if (d_move) begin
        res_nxt = opnd_r;
      end else begin
        res_nxt = opnd_r + 8'h01;
      end
      if (exec && d_byte && w[cie_pkg::BIT_DIR]) begin
        wr_nxt = '{1'b1, rd_r.addr, res_nxt};
      end else if (word2 && pmff_r && w[11:0] != ACC_LOC) begin
        wr_nxt = '{1'b1, w[11:0], opnd_r};
      end
    end
    // Write phase: commit registers and pick the next cycle's role
    if (q[3]) begin
      wr_nxt.we = 1'b0;
      case (st_r)
        cie_pkg::ST_EXEC: begin
          if (d_or_lit || (d_byte && !w[cie_pkg::BIT_DIR])) begin
            acc_nxt = res_r;
          end
          if (d_or_lit || d_or_reg || d_move) begin
            stat_nxt[cie_pkg::ST_N] = res_r[7];
            stat_nxt[cie_pkg::ST_Z] = res_r == 8'h00;
          end
          if (d_bank) begin
            bank_nxt = w[3:0];
          end
          if (d_ldptr) begin
            pidx_nxt = w[5:4];
            pmff_nxt = 1'b0;
            st_nxt = cie_pkg::ST_WORD2;
            if (w[5:4] != cie_pkg::PTR_NONE) begin
              ptr_nxt[w[5:4]][11:8] = w[3:0];
            end
          end
          if (d_mff) begin
            pmff_nxt = 1'b1;
            st_nxt = cie_pkg::ST_WORD2;
          end
          if (skip_hit) begin
            st_nxt = cie_pkg::ST_SKIP;
          end
        end
        cie_pkg::ST_WORD2: begin
          if (pmff_r && w[11:0] == ACC_LOC) begin
            acc_nxt = opnd_r;
          end else if (!pmff_r && pidx_r != cie_pkg::PTR_NONE) begin
            ptr_nxt[pidx_r][7:0] = w[7:0];
          end
          st_nxt = cie_pkg::ST_EXEC;
        end
        cie_pkg::ST_SKIP: begin
          st_nxt = cie_pkg::is_two_word(w) ? cie_pkg::ST_SKIP2 : cie_pkg::ST_EXEC;
        end
        default: st_nxt = cie_pkg::ST_EXEC;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r <= cie_pkg::ST_EXEC;
      ir_r <= 16'h0000;
      opnd_r <= 8'h00;
      res_r <= 8'h00;
      acc_r <= cie_pkg::ACC_RST;
      bank_r <= cie_pkg::BANK_RST;
      stat_r <= cie_pkg::STATUS_RST;
      ctrl_r <= cie_pkg::CTRL_RST;
      pidx_r <= 2'h0;
      pmff_r <= 1'b0;
      for (int i = 0; i < 3; i++) begin
        ptr_r[i] <= cie_pkg::PTR_RST;
      end
      rd_r <= '0;
      wr_r <= '0;
    end else begin
      st_r <= st_nxt;
      ir_r <= ir_nxt;
      opnd_r <= opnd_nxt;
      res_r <= res_nxt;
      acc_r <= acc_nxt;
      bank_r <= bank_nxt;
      stat_r <= stat_nxt;
      ctrl_r <= ctrl_nxt;
      pidx_r <= pidx_nxt;
      pmff_r <= pmff_nxt;
      ptr_r <= ptr_nxt;
      rd_r <= rd_nxt;
      wr_r <= wr_nxt;
    end
  end

  // Bus slave: zero wait; reads other than state use next values so a write just ahead is seen
  assign bus_ph = hsel && htrans[1] && hready;
  always_comb begin
    bw_nxt = bus_ph && hwrite;
    ba_nxt = bus_ph ? haddr[7:0] : ba_r;
    hrdata_nxt = hrdata_r;
    if (bus_ph && !hwrite) begin
      case (haddr[7:0])
        cie_pkg::OFS_CTRL: hrdata_nxt = {30'h0, ctrl_nxt};
        cie_pkg::OFS_ACC: hrdata_nxt = {24'h0, acc_nxt};
        cie_pkg::OFS_BANK: hrdata_nxt = {28'h0, bank_nxt};
        cie_pkg::OFS_STATUS: hrdata_nxt = {27'h0, stat_nxt};
        cie_pkg::OFS_PTR0: hrdata_nxt = {20'h0, ptr_nxt[0]};
        cie_pkg::OFS_PTR1: hrdata_nxt = {20'h0, ptr_nxt[1]};
        cie_pkg::OFS_PTR2: hrdata_nxt = {20'h0, ptr_nxt[2]};
        cie_pkg::OFS_STATE: hrdata_nxt = {28'h0, st_r};
        default: hrdata_nxt = 32'h0;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bw_r <= 1'b0;
      ba_r <= 8'h00;
      hrdata_r <= 32'h0;
    end else begin
      bw_r <= bw_nxt;
      ba_r <= ba_nxt;
      hrdata_r <= hrdata_nxt;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_r;
  assign instr_take = q[0];
  assign dm_rd = rd_r;
  assign dm_wr = wr_r;

  // Checks on the execute sequence
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  or_lit_acc_a: assert property ((q[2] && exec && d_or_lit && !bw_r) ##1 !bw_r
    |=> acc_r == ($past(acc_r, 2) | $past(ir_r[7:0], 2))) else $error("or literal result");
  nz_flags_a: assert property (q[3] && exec && (d_or_lit || d_or_reg || d_move) && !bw_r
    |=> stat_r[cie_pkg::ST_N] == $past(res_r[7]) && stat_r[cie_pkg::ST_Z] == ($past(res_r) == 8'h00)
    && stat_r[1:0] == $past(stat_r[1:0]) && stat_r[3] == $past(stat_r[3]))
    else $error("or or move flags wrong");
  inc_flags_a: assert property (q[3] && exec && (d_inc_z || d_inc_nz) && !bw_r
    |=> $stable(stat_r)) else $error("increment changed flags");
  dir_write_a: assert property (q[2] && exec && d_byte
    |=> wr_r.we == $past(ir_r[cie_pkg::BIT_DIR]) && (!wr_r.we || wr_r.addr == rd_r.addr)
    ##1 !wr_r.we) else $error("destination select wrong");
  bank_addr_a: assert property (q[1] && exec && d_byte && ir_r[cie_pkg::BIT_ACC] && !$past(bw_r)
    |-> rd_r.re && rd_r.addr == {bank_r, ir_r[7:0]}) else $error("banked address wrong");
  indexed_a: assert property (q[1] && exec && d_byte && !ir_r[cie_pkg::BIT_ACC] && !$past(bw_r)
    && ctrl_r[cie_pkg::CTRL_EXT] && ir_r[7:0] <= cie_pkg::INDEXED_MAX
    |-> rd_r.addr == ptr_r[2] + {4'h0, ir_r[7:0]}) else $error("indexed address wrong");
  bank_load_a: assert property (q[3] && exec && d_bank
    |=> bank_r == $past(ir_r[3:0]) && st_r == cie_pkg::ST_EXEC) else $error("bank load wrong");
  ptr_high_a: assert property (q[3] && exec && d_ldptr && ir_r[5:4] != cie_pkg::PTR_NONE
    |=> st_r == cie_pkg::ST_WORD2 && ptr_r[$past(ir_r[5:4])][11:8] == $past(ir_r[3:0]))
    else $error("pointer high part wrong");
  mff_write_a: assert property (q[2] && word2 && pmff_r && ir_r[11:0] != ACC_LOC
    |=> wr_r.we && wr_r.addr == $past(ir_r[11:0]) && wr_r.data == $past(opnd_r) ##1 !wr_r.we)
    else $error("file move write wrong");
  mff_noread_a: assert property (word2 && !q[0] |-> !rd_r.re) else $error("second word read");
  skip_enter_a: assert property (q[3] && exec && skip_hit
    |=> st_r == cie_pkg::ST_SKIP && !wr_r.we) else $error("skip not taken");
  skip_two_a: assert property (q[3] && st_r == cie_pkg::ST_SKIP && cie_pkg::is_two_word(ir_r)
    |=> st_r == cie_pkg::ST_SKIP2) else $error("two-word skip short");
  phase_seq_a: assert property ((q[0] ##1 ctrl_r[cie_pkg::CTRL_RUN]) |-> q[1] && $onehot(q))
    else $error("phase order broken");

  skip2_c: cover property (q[3] && st_r == cie_pkg::ST_SKIP2);
  mff_c: cover property (q[3] && word2 && pmff_r && wr_r.we);
  ldptr_c: cover property (q[3] && word2 && !pmff_r);
  or_lit_c: cover property (q[3] && exec && d_or_lit);
endmodule : cie_core

//--- cie_tb.sv
// Self-checking bench for the core execute slice
`timescale 1ns/1ps
module tb;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, instr_take;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [15:0] instr_word;
  logic [7:0] dm_rdata, rnd, acc, m, f, v;
  cie_pkg::cie_dm_rd_t dm_rd;
  cie_pkg::cie_dm_wr_t dm_wr;
  logic [7:0] mem [0:4095];
  logic [15:0] prog [0:63];
  logic [11:0] k [0:2];
  logic [11:0] a12;
  logic [3:0] bank;
  logic [4:0] st;
  int pc, wp, failures, n_checks, n_re, n_we, cyc, last_take, r0, w0;

  cie_core uut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .instr_word(instr_word),
    .instr_take(instr_take), .dm_rd(dm_rd), .dm_rdata(dm_rdata), .dm_wr(dm_wr)
  );

  // Single slave, so its ready is the bus ready
  assign hready = hreadyout;
  assign instr_word = prog[pc];
  // Unselected memory shows inverted data so a stray capture is caught
  assign dm_rdata = dm_rd.re ? mem[dm_rd.addr] : ~mem[dm_rd.addr];

  initial begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end

  // Memory writes, fetch pointer and cycle spacing of takes
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (dm_wr.we === 1'b1) mem[dm_wr.addr] <= dm_wr.data;
    if (dm_wr.we === 1'b1) n_we <= n_we + 1;
    if (dm_rd.re === 1'b1) n_re <= n_re + 1;
    if (instr_take === 1'b1) begin
      if (pc < wp) pc <= pc + 1;
      if (last_take > 0) chk("take_gap", 32'(cie_pkg::PHASES), 32'(cyc - last_take));
      last_take <= cyc;
    end
  end

  function automatic logic [7:0] load_indirect_pointer(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : load_indirect_pointer

  // Only negative and zero follow the result
  function automatic logic [4:0] nz(input logic [4:0] o, input logic [7:0] r);
    return {r[7], o[3], r == 8'h00, o[1:0]};
  endfunction : nz

  task automatic draw(output logic [7:0] x);
    rnd = load_indirect_pointer(rnd);
    x = rnd;
  endtask : draw

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // One AHB-Lite single word transfer; read data taken at the data phase edge
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    haddr <= {24'h000000, a};
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr

  task automatic chk_reg(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h00000000);
    chk($sformatf("reg_%h", a), exp, rd);
    chk("hresp", 32'h00000000, {31'h00000000, hresp});
  endtask : chk_reg

  task automatic chk_mem(input logic [11:0] a, input logic [7:0] exp);
    chk($sformatf("mem_%h", a), {24'h000000, exp}, {24'h000000, mem[a]});
  endtask : chk_mem

  // One word per edge by non-blocking update, so a fetch on that edge never races it
  task automatic put(input logic [15:0] w);
    @(posedge hclk);
    prog[wp] <= w;
    wp <= wp + 1;
  endtask : put

  // Wait until every queued word is taken, then let the last one finish
  task automatic go(input string name);
    int n;
    n = 0;
    // Let the last queued word land before looking at the fetch pointer
    @(posedge hclk);
    while (pc < wp && n < 400) begin
      @(posedge hclk);
      n++;
    end
    chk("drained", 32'(wp), 32'(pc));
    repeat (6) @(posedge hclk);
    $display("test %s done", name);
  endtask : go

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : report_and_stop

  // Watchdog well beyond the expected few hundred cycles
  initial begin
    repeat (20000) @(posedge hclk);
    failures++;
    report_and_stop();
  end

  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    htrans = 2'b00;
    hwrite = 1'b0;
    haddr = 32'h00000000;
    hwdata = 32'h00000000;
    hsize = 3'b010;
    pc = 0;
    wp = 0;
    cyc = 0;
    last_take = 0;
    n_re = 0;
    n_we = 0;
    rnd = 8'h47;
    for (int i = 0; i < 64; i++) prog[i] = 16'h0000;
    for (int i = 0; i < 4096; i++) draw(mem[i]);
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    // Reset values, one unmapped slot included
    for (int i = 0; i < 9; i++) chk_reg(8'(4 * i), (i == 7) ? 32'h00000001 : 32'h00000000);
    wr(cie_pkg::OFS_BANK, 32'h000000ff);
    chk_reg(cie_pkg::OFS_BANK, 32'h0000000f);
    wr(cie_pkg::OFS_PTR0, 32'h00000fff);
    chk_reg(cie_pkg::OFS_PTR0, 32'h00000000);
    wr(8'h20, 32'hffffffff);
    chk_reg(8'h20, 32'h00000000);
    $display("test registers done");
    draw(acc);
    wr(cie_pkg::OFS_ACC, {24'h000000, acc});
    st = 5'h0b;
    wr(cie_pkg::OFS_STATUS, {27'h0000000, st});
    wr(cie_pkg::OFS_CTRL, 32'h00000003);
    // Or with literal
    draw(f);
    put({8'h09, f});
    go("or_literal");
    acc = acc | f;
    st = nz(st, acc);
    chk_reg(cie_pkg::OFS_ACC, {24'h000000, acc});
    chk_reg(cie_pkg::OFS_STATUS, {27'h0000000, st});
    // Or with register through the bank selector, result back to memory
    draw(m);
    bank = {1'b1, m[2:0]};
    wr(cie_pkg::OFS_BANK, {28'h0000000, bank});
    draw(f);
    a12 = {bank, f};
    v = mem[a12] | acc;
    put({8'h13, f});
    go("or_register");
    st = nz(st, v);
    chk_mem(a12, v);
    chk_reg(cie_pkg::OFS_ACC, {24'h000000, acc});
    chk_reg(cie_pkg::OFS_STATUS, {27'h0000000, st});
    // Move from the high access region at its first offset
    mem[12'hf60] = 8'h00;
    put(16'h5060);
    go("move_access");
    acc = 8'h00;
    st = nz(st, acc);
    chk_reg(cie_pkg::OFS_ACC, 32'h00000000);
    chk_reg(cie_pkg::OFS_STATUS, {27'h0000000, st});
    // Load all three pointers
    for (int i = 0; i < 3; i++) begin
      draw(m);
      draw(f);
      k[i] = {m[3:0], f};
      put({8'hee, 2'b00, 2'(i), k[i][11:8]});
      put({8'hf0, k[i][7:0]});
    end
    go("pointers");
    for (int i = 0; i < 3; i++) chk_reg(8'(8'h10 + 4 * i), {20'h00000, k[i]});
    // Indexed offset at the last indexed address
    a12 = k[2] + 12'h05f;
    v = mem[a12] | acc;
    put(16'h125f);
    go("indexed");
    st = nz(st, v);
    chk_mem(a12, v);
    // Increment to zero skips a bank load
    draw(f);
    a12 = {bank, f};
    mem[a12] = 8'hff;
    put({8'h3f, f});
    put(16'h01a5);
    go("inc_zero");
    chk_mem(a12, 8'h00);
    chk_reg(cie_pkg::OFS_BANK, {28'h0000000, bank});
    chk_reg(cie_pkg::OFS_STATUS, {27'h0000000, st});
    // Increment to non-zero skips a two-word move whole
    draw(f);
    a12 = {bank, f};
    mem[a12] = 8'h10;
    mem[12'h123] = ~mem[12'h456];
    v = mem[12'h456];
    put({8'h49, f});
    put(16'hc123);
    put(16'hf456);
    go("inc_nonzero");
    acc = 8'h11;
    chk_reg(cie_pkg::OFS_ACC, {24'h000000, acc});
    chk_mem(12'h456, v);
    chk_reg(cie_pkg::OFS_STATUS, {27'h0000000, st});
    // Bank load drops the upper nibble
    put(16'h01a7);
    go("bank_load");
    chk_reg(cie_pkg::OFS_BANK, 32'h00000007);
    // File move between the extreme addresses, from 000 to fff
    v = mem[12'h000];
    r0 = n_re;
    w0 = n_we;
    put(16'hc000);
    put(16'hffff);
    go("move_file");
    chk_mem(12'hfff, v);
    chk("reads", 32'h00000001, 32'(n_re - r0));
    chk("writes", 32'h00000001, 32'(n_we - w0));
    // Accumulator as source, then as destination
    r0 = n_re;
    put(16'hcfe8);
    put(16'hf789);
    go("move_from_acc");
    chk_mem(12'h789, acc);
    chk("acc_src_reads", 32'h00000000, 32'(n_re - r0));
    acc = mem[12'h456];
    put(16'hc456);
    put(16'hffe8);
    go("move_to_acc");
    chk_reg(cie_pkg::OFS_ACC, {24'h000000, acc});
    chk_reg(cie_pkg::OFS_STATUS, {27'h0000000, st});
    // Low access half with the extended set off; or result goes to the accumulator
    wr(cie_pkg::OFS_CTRL, 32'h00000002);
    draw(f);
    f = f & 8'h5f;
    v = mem[{4'h0, f}] | acc;
    put({8'h10, f});
    go("or_access_low");
    acc = v;
    st = nz(st, v);
    chk_reg(cie_pkg::OFS_ACC, {24'h000000, acc});
    chk_reg(cie_pkg::OFS_STATUS, {27'h0000000, st});
    report_and_stop();
  end
endmodule : tb
